// *** hw/dem_pkg.sv ***
/*
 * Shared constants of the dual encoder motion feedback block.
 * Assumes a 100 MHz system clock and an 8-bit register address space.
 */
package dem_pkg;
	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [7:0] ADDR_POSITION = 8'h26;
	localparam logic [7:0] ADDR_SPEED = 8'h28;
	localparam logic [7:0] ADDR_FLAGS = 8'h2c;
	localparam logic [7:0] ADDR_TUNE = 8'h39;
	localparam logic [7:0] ADDR_RATIO = 8'h44;
	localparam logic [7:0] ADDR_LOOP_SEL = 8'h50;
	localparam logic [7:0] ADDR_SAVE = 8'h51;
	localparam logic [7:0] ADDR_NET_ADDR = 8'h52;

	// ********************************************************************
	// Field positions and reset values
	// ********************************************************************
	localparam int FLAG_DUAL_BIT = 10;
	localparam int FLAG_INV2_BIT = 11;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
	localparam logic [31:0] RATIO_RESET = 32'h0001_0000;
	localparam int RATIO_FRAC = 16;
	localparam logic [31:0] NET_ADDR_RESET = 32'h0000_0000;

	// Regulation modes written to the loop select register.
	localparam logic [2:0] LOOP_BRAKE = 3'h0;
	localparam logic [2:0] LOOP_OPEN = 3'h1;
	localparam logic [2:0] LOOP_SPEED = 3'h2;
	localparam logic [2:0] LOOP_POSITION = 3'h3;
	localparam logic [2:0] LOOP_DRIVER_OPEN = 3'h4;

	// Trajectory phases and LED colours.
	localparam logic [1:0] PHASE_ACCEL = 2'h0;
	localparam logic [1:0] PHASE_TOP = 2'h1;
	localparam logic [1:0] PHASE_DECEL = 2'h2;
	localparam logic [1:0] LED_GREEN = 2'h1;
	localparam logic [1:0] LED_YELLOW = 2'h2;
	localparam logic [1:0] LED_RED = 2'h3;

	// PWM duty scale: full duty is 65536, three quarters is 49152.
	localparam logic [16:0] DUTY_FULL = 17'h1_0000;
	localparam logic [16:0] DUTY_75 = 17'h0_c000;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int GATE_MS = 10;
	localparam int GATE_CYC = GATE_MS * (CLK_HZ / 1000);
	localparam int SPEED_SCALE = 1000 / GATE_MS;
	localparam int TUNE_MS = 1000;
	localparam int TUNE_CYC = TUNE_MS * (CLK_HZ / 1000);
	localparam int DIV_STEPS = 48;
endpackage

// *** hw/dem_enc_if.sv ***
/*
 * Pulse events from one quadrature decoder to the feedback logic.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface dem_enc_if;
	logic step;
	logic dir;
	modport src(output step, output dir);
	modport snk(input step, input dir);
endinterface

// *** hw/dem_quad_counter.sv ***
/*
 * Quadrature decoder giving one step per edge of either channel.
 * Assumes channel inputs already synchronous to mclk.
 */
`timescale 1ns/1ps
module dem_quad_counter (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic chan_a,
	input wire logic chan_b,
	input wire logic enable,
	input wire logic invert,
	dem_enc_if.src enc
);
	logic a_q;
	logic b_q;

	// Previous channel levels, used to find edges.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= chan_a;
			b_q <= chan_b;
		end
	end

	// Any edge on A or B is one pulse, so four per cycle.
	// A disabled decoder reports no steps; dir still follows the channels.
	assign enc.step = enable & ((chan_a ^ a_q) | (chan_b ^ b_q));
	// Direction reversal is a plain flip of the decoded sense.
	assign enc.dir = (a_q ^ chan_b) ^ invert;
endmodule

// *** hw/dem_motion_feedback.sv ***
/*
 * Feedback and safety logic of a dual encoder motor controller: counting,
 * speed, trajectory feedback selection, ratio handling, brake, LED, save.
 * Assumes synchronous inputs, a single-cycle register port and an outside
 * power stage and nonvolatile memory that act on the outputs given here.
 */
`timescale 1ns/1ps
module dem_motion_feedback #(
	parameter int GATE_CYCLES = dem_pkg::GATE_CYC,
	parameter int TUNE_CYCLES = dem_pkg::TUNE_CYC,
	parameter int DECEL_SHIFT = 4
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic enc1_a,
	input wire logic enc1_b,
	input wire logic enc2_a,
	input wire logic enc2_b,
	input wire logic drive_enable,
	input wire logic [16:0] pwm_duty,
	input wire logic [1:0] traj_phase,
	input wire logic [31:0] traj_speed_cmd,
	input wire logic [31:0] traj_target,
	input wire logic [7:0] client_count,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic [2:0] drive_mode,
	output logic [31:0] motor_speed_cmd,
	output logic [31:0] traj_feedback,
	output logic [1:0] led_colour,
	output logic [31:0] net_addr_active,
	output logic nv_save,
	output logic [98:0] nv_data
);
	// ********************************************************************
	// Decoders
	// ********************************************************************
	dem_enc_if enc1();
	dem_enc_if enc2();
	logic [31:0] flags_q;
	logic dual;

	assign dual = flags_q[dem_pkg::FLAG_DUAL_BIT];

	dem_quad_counter u_enc1 (
		.mclk(mclk),
		.rst_b(rst_b),
		.chan_a(enc1_a),
		.chan_b(enc1_b),
		.enable(1'b1),
		.invert(1'b0),
		.enc(enc1.src)
	);

	dem_quad_counter u_enc2 (
		.mclk(mclk),
		.rst_b(rst_b),
		.chan_a(enc2_a),
		.chan_b(enc2_b),
		.enable(dual),
		.invert(flags_q[dem_pkg::FLAG_INV2_BIT]),
		.enc(enc2.src)
	);

	// Signed one-step increment from a decoder event.
	function automatic logic [31:0] step_inc(input logic step, input logic dir);
		step_inc = step ? (dir ? 32'hffff_ffff : 32'h0000_0001) : 32'h0000_0000;
	endfunction

	// ********************************************************************
	// Counting and speed
	// ********************************************************************
	logic [31:0] cnt1_q;
	logic [31:0] cnt2_q;
	logic [31:0] delta_q;
	logic [31:0] speed_q;
	logic [31:0] gate_q;
	logic [31:0] position;

	// Running counts of both encoders.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt1_q <= 32'h0000_0000;
			cnt2_q <= 32'h0000_0000;
		end else begin
			cnt1_q <= cnt1_q + step_inc(enc1.step, enc1.dir);
			cnt2_q <= cnt2_q + step_inc(enc2.step, enc2.dir);
		end
	end

	// Speed is counted on the motor encoder over a short gate and scaled up to
	// pulses per second; a short gate trades resolution for fresher readings.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			gate_q <= 32'h0000_0000;
			delta_q <= 32'h0000_0000;
			speed_q <= 32'h0000_0000;
		end else if (gate_q == 32'(GATE_CYCLES - 1)) begin
			gate_q <= 32'h0000_0000;
			delta_q <= 32'h0000_0000;
			speed_q <= 32'((delta_q + step_inc(enc1.step, enc1.dir)) * dem_pkg::SPEED_SCALE);
		end else begin
			gate_q <= gate_q + 32'h0000_0001;
			delta_q <= delta_q + step_inc(enc1.step, enc1.dir);
		end
	end

	// Position follows the output encoder in dual mode, else the motor one.
	assign position = dual ? cnt2_q : cnt1_q;

	// ********************************************************************
	// Trajectory feedback and command conversion
	// ********************************************************************
	logic [31:0] ratio_q;
	logic [31:0] decel_cmd2;
	logic [64:0] decel_prod;
	logic decel;

	assign decel = dual && (traj_phase == dem_pkg::PHASE_DECEL);
	// Deceleration speed in second encoder units from remaining distance.
	assign decel_cmd2 = $signed(traj_target - cnt2_q) >>> DECEL_SHIFT;
	assign decel_prod = $signed(decel_cmd2) * $signed({1'b0, ratio_q});

	// Accel and top phases track the motor encoder; in dual mode decel is re-spaced by the ratio.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			traj_feedback <= 32'h0000_0000;
			motor_speed_cmd <= 32'h0000_0000;
		end else if (decel) begin
			traj_feedback <= cnt2_q;
			motor_speed_cmd <= decel_prod[dem_pkg::RATIO_FRAC +: 32];
		end else begin
			traj_feedback <= cnt1_q;
			motor_speed_cmd <= traj_speed_cmd;
		end
	end

	// ********************************************************************
	// Ratio auto-tuning
	// ********************************************************************
	typedef enum {TUNE_IDLE, TUNE_MEAS, TUNE_DIV} dem_tune_t;
	dem_tune_t tune_q;
	logic [31:0] tune_cnt_q;
	logic [31:0] d1_q;
	logic [31:0] d2_q;
	logic [47:0] num_q;
	logic [32:0] rem_q;
	logic [31:0] quo_q;
	logic [32:0] rem_sh;
	logic ratio_done;

	// Magnitude of a signed count.
	function automatic logic [31:0] mag(input logic [31:0] v);
		mag = v[31] ? (~v + 32'h0000_0001) : v;
	endfunction

	assign rem_sh = {rem_q[31:0], num_q[47]};
	assign ratio_done = (tune_q == TUNE_DIV) && (tune_cnt_q == 32'(dem_pkg::DIV_STEPS));

	// Move counts are gathered over a window, then divided bit by bit to
	// keep the area small; a window with no output motion leaves the ratio.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tune_q <= TUNE_IDLE;
			tune_cnt_q <= 32'h0000_0000;
			d1_q <= 32'h0000_0000;
			d2_q <= 32'h0000_0000;
			num_q <= 48'h0000_0000_0000;
			rem_q <= 33'h0_0000_0000;
			quo_q <= 32'h0000_0000;
		end else begin
			case (tune_q)
				TUNE_IDLE: begin
					if (reg_wr && reg_addr == dem_pkg::ADDR_TUNE && dual) begin
						tune_q <= TUNE_MEAS;
						tune_cnt_q <= 32'h0000_0000;
						d1_q <= 32'h0000_0000;
						d2_q <= 32'h0000_0000;
					end
				end
				TUNE_MEAS: begin
					d1_q <= d1_q + step_inc(enc1.step, enc1.dir);
					d2_q <= d2_q + step_inc(enc2.step, enc2.dir);
					tune_cnt_q <= tune_cnt_q + 32'h0000_0001;
					if (!dual) begin
						tune_q <= TUNE_IDLE;
					end else if (tune_cnt_q == 32'(TUNE_CYCLES - 1)) begin
						tune_q <= ((d2_q + step_inc(enc2.step, enc2.dir)) == 32'h0000_0000) ? TUNE_IDLE : TUNE_DIV;
						tune_cnt_q <= 32'h0000_0000;
						num_q <= {mag(d1_q + step_inc(enc1.step, enc1.dir)), 16'h0000};
						d2_q <= mag(d2_q + step_inc(enc2.step, enc2.dir));
						rem_q <= 33'h0_0000_0000;
					end
				end
				TUNE_DIV: begin
					if (ratio_done) begin
						tune_q <= TUNE_IDLE;
					end else begin
						num_q <= {num_q[46:0], 1'b0};
						tune_cnt_q <= tune_cnt_q + 32'h0000_0001;
						if (rem_sh >= {1'b0, d2_q}) begin
							rem_q <= rem_sh - {1'b0, d2_q};
							quo_q <= {quo_q[30:0], 1'b1};
						end else begin
							rem_q <= rem_sh;
							quo_q <= {quo_q[30:0], 1'b0};
						end
					end
				end
				default: tune_q <= TUNE_IDLE;
			endcase
		end
	end

	// ********************************************************************
	// Registers
	// ********************************************************************
	logic [31:0] net_addr_q;

	// Host written settings; the estimated ratio wins over a host write.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			flags_q <= dem_pkg::FLAGS_RESET;
			ratio_q <= dem_pkg::RATIO_RESET;
			net_addr_q <= dem_pkg::NET_ADDR_RESET;
		end else begin
			if (reg_wr && reg_addr == dem_pkg::ADDR_FLAGS) begin
				flags_q <= reg_wdata;
			end
			if (ratio_done) begin
				ratio_q <= quo_q;
			end else if (reg_wr && reg_addr == dem_pkg::ADDR_RATIO) begin
				ratio_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == dem_pkg::ADDR_NET_ADDR) begin
				net_addr_q <= reg_wdata;
			end
		end
	end

	// The pending address moves over only while nobody is connected, so an open
	// session is never cut off mid-exchange.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			net_addr_active <= dem_pkg::NET_ADDR_RESET;
		end else if (client_count == 8'h00) begin
			net_addr_active <= net_addr_q;
		end
	end

	// Regulation mode: a low enable forces brake and also overrides a write in
	// the same cycle; brake is held until the host picks a mode again.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			drive_mode <= dem_pkg::LOOP_BRAKE;
		end else if (!drive_enable) begin
			drive_mode <= dem_pkg::LOOP_BRAKE;
		end else if (reg_wr && reg_addr == dem_pkg::ADDR_LOOP_SEL) begin
			drive_mode <= reg_wdata[2:0];
		end
	end

	// Save snapshot of every saveable register, with a one-cycle strobe.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			nv_save <= 1'b0;
			nv_data <= 99'h0;
		end else begin
			nv_save <= reg_wr && reg_addr == dem_pkg::ADDR_SAVE;
			if (reg_wr && reg_addr == dem_pkg::ADDR_SAVE) begin
				nv_data <= {drive_mode, net_addr_q, ratio_q, flags_q};
			end
		end
	end

	// Read port; write-only and unmapped offsets read as zero.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				dem_pkg::ADDR_POSITION: reg_rdata <= position;
				dem_pkg::ADDR_SPEED: reg_rdata <= speed_q;
				dem_pkg::ADDR_FLAGS: reg_rdata <= flags_q;
				dem_pkg::ADDR_RATIO: reg_rdata <= ratio_q;
				dem_pkg::ADDR_LOOP_SEL: reg_rdata <= {29'h0, drive_mode};
				dem_pkg::ADDR_NET_ADDR: reg_rdata <= net_addr_q;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ********************************************************************
	// Status LED
	// ********************************************************************
	// Colour from PWM duty; full duty often means current limiting.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			led_colour <= dem_pkg::LED_GREEN;
		end else if (pwm_duty >= dem_pkg::DUTY_FULL) begin
			led_colour <= dem_pkg::LED_RED;
		end else if (pwm_duty > dem_pkg::DUTY_75) begin
			led_colour <= dem_pkg::LED_YELLOW;
		end else begin
			led_colour <= dem_pkg::LED_GREEN;
		end
	end
endmodule

// *** tb/dem_assertions.sv ***
/*
 * Port checker of the motion feedback block.
 * Assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/1ps
module dem_assertions (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic drive_enable,
	input wire logic [16:0] pwm_duty,
	input wire logic [1:0] traj_phase,
	input wire logic [31:0] traj_speed_cmd,
	input wire logic [7:0] client_count,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic [2:0] drive_mode,
	input wire logic [31:0] motor_speed_cmd,
	input wire logic [1:0] led_colour,
	input wire logic [31:0] net_addr_active,
	input wire logic nv_save
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic mode_wr;
	logic save_wr;
	// Decoded writes, kept apart so that properties stay short.
	assign mode_wr = reg_wr && reg_addr == dem_pkg::ADDR_LOOP_SEL;
	assign save_wr = reg_wr && reg_addr == dem_pkg::ADDR_SAVE;

	a_brake_forced: assert property (!drive_enable |=> drive_mode == dem_pkg::LOOP_BRAKE)
		else $error("mode not brake after enable low");
	a_brake_kept: assert property (drive_mode == 3'h0 && !mode_wr |=> drive_mode == 3'h0)
		else $error("brake left without a mode write");
	a_mode_taken: assert property (drive_enable && mode_wr |=> drive_mode == $past(reg_wdata[2:0]))
		else $error("mode write not applied");
	a_led_red: assert property (pwm_duty >= dem_pkg::DUTY_FULL |=> led_colour == dem_pkg::LED_RED)
		else $error("led not red at full duty");
	a_led_yellow: assert property (pwm_duty > dem_pkg::DUTY_75 && pwm_duty < dem_pkg::DUTY_FULL |=>
		led_colour == dem_pkg::LED_YELLOW) else $error("led not yellow");
	a_led_green: assert property (pwm_duty <= dem_pkg::DUTY_75 |=> led_colour == dem_pkg::LED_GREEN)
		else $error("led not green");
	a_addr_held: assert property (client_count != 8'h00 |=> $stable(net_addr_active))
		else $error("address changed with clients");
	a_save_pulse: assert property (save_wr |=> nv_save)
		else $error("save pulse missing");
	a_save_cause: assert property (nv_save |-> $past(save_wr))
		else $error("save pulse without command");
	a_cmd_follow: assert property (traj_phase == dem_pkg::PHASE_ACCEL || traj_phase == dem_pkg::PHASE_TOP |=>
		motor_speed_cmd == $past(traj_speed_cmd)) else $error("speed command not followed");
	a_wo_zero: assert property (reg_rd && reg_addr == dem_pkg::ADDR_TUNE |=> reg_rdata == 32'h0)
		else $error("trigger read not zero");

	c_save: cover property (nv_save);
	c_rearm: cover property (!drive_enable ##1 drive_enable);
	c_red: cover property (led_colour == dem_pkg::LED_RED);
endmodule

bind dem_motion_feedback dem_assertions u_chk (.mclk(mclk), .rst_b(rst_b), .drive_enable(drive_enable),
	.pwm_duty(pwm_duty), .traj_phase(traj_phase), .traj_speed_cmd(traj_speed_cmd),
	.client_count(client_count), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drive_mode(drive_mode),
	.motor_speed_cmd(motor_speed_cmd), .led_colour(led_colour),
	.net_addr_active(net_addr_active), .nv_save(nv_save));

// *** tb/dem_enc_model.sv ***
/*
 * Behavioural quadrature encoder with a fixed step period.
 * Assumes en, fwd and period change just after a clock edge.
 */
`timescale 1ns/1ps
module dem_enc_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic fwd,
	input wire logic [7:0] period,
	output logic a,
	output logic b
);
	logic [7:0] cnt_q;
	logic [1:0] ph_q;
	// One gray step per period, so only one channel moves at a time.
	always_ff @(posedge mclk) begin
		if (!rst_b || !en) begin
			cnt_q <= 8'h00;
		end else if (cnt_q == period - 8'h01) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	// The phase is kept while stopped, like a shaft at rest.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ph_q <= 2'h0;
		end else if (en && cnt_q == period - 8'h01) begin
			ph_q <= fwd ? ph_q + 2'h1 : ph_q - 2'h1;
		end
	end
	// Order 00, 10, 11, 01 as (a, b): four edges per cycle, forward counts up.
	assign a = ph_q[1] ^ ph_q[0];
	assign b = ph_q[1];
endmodule

// *** tb/tb.sv ***
/*
 * Self-checking bench of the motion feedback block with two encoders.
 * Assumes the shortened gate and tuning counts given at the instance.
 */
`timescale 1ns/1ps
module tb;
	logic mclk, rst_b, drive_enable, reg_wr, reg_rd, rd_p, nv_save;
	logic enc1_a, enc1_b, enc2_a, enc2_b, e1, e2, f1, f2;
	logic [7:0] p1, p2, client_count, reg_addr;
	logic [16:0] pwm_duty;
	logic [1:0] traj_phase, led_colour;
	logic [31:0] traj_speed_cmd, traj_target, reg_wdata, reg_rdata;
	logic [31:0] motor_speed_cmd, traj_feedback, net_addr_active;
	logic [2:0] drive_mode;
	logic [98:0] nv_data;
	logic [98:0] rq[$];
	logic [98:0] sq[$];
	logic [16:0] dl[5] = '{17'h0, 17'h0_c000, 17'h0_c001, 17'h0_ffff, 17'h1_0000};
	int n_mismatch = 0;
	int n_checks = 0;

	dem_motion_feedback #(.GATE_CYCLES(100), .TUNE_CYCLES(200), .DECEL_SHIFT(4)) DUT (.mclk(mclk),
		.rst_b(rst_b), .enc1_a(enc1_a), .enc1_b(enc1_b), .enc2_a(enc2_a), .enc2_b(enc2_b),
		.drive_enable(drive_enable), .pwm_duty(pwm_duty), .traj_phase(traj_phase),
		.traj_speed_cmd(traj_speed_cmd), .traj_target(traj_target), .client_count(client_count),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .drive_mode(drive_mode), .motor_speed_cmd(motor_speed_cmd),
		.traj_feedback(traj_feedback), .led_colour(led_colour), .net_addr_active(net_addr_active),
		.nv_save(nv_save), .nv_data(nv_data));
	dem_enc_model u_enc1 (.mclk(mclk), .rst_b(rst_b), .en(e1), .fwd(f1), .period(p1), .a(enc1_a), .b(enc1_b));
	dem_enc_model u_enc2 (.mclk(mclk), .rst_b(rst_b), .en(e2), .fwd(f2), .period(p2), .a(enc2_a), .b(enc2_b));

	// ********************************************************************
	// Tasks
	// ********************************************************************
	task chk(input string nm, input logic [98:0] e, input logic [98:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc;
		@(posedge mclk);
		#1;
	endtask
	// Each access ends with an idle cycle so a strobe is never set twice at once.
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc;
		reg_wr = 1'b0;
		cyc;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back({67'h0, e});
		reg_addr = a;
		reg_rd = 1'b1;
		cyc;
		reg_rd = 1'b0;
		cyc;
	endtask
	// A zero period leaves that encoder at rest.
	task go(input logic [7:0] q1, input logic d1, input logic [7:0] q2, input logic d2, input int n);
		p1 = q1;
		f1 = d1;
		e1 = q1 != 8'h00;
		p2 = q2;
		f2 = d2;
		e2 = q2 != 8'h00;
		repeat (n) cyc;
		e1 = 1'b0;
		e2 = 1'b0;
		repeat (3) cyc;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Results are taken at the falling edge, where registered outputs have settled.
	always @(posedge mclk) rd_p <= reg_rd;
	always @(negedge mclk) begin
		if (rd_p === 1'b1) begin
			chk("reg_rdata", rq.size() != 0 ? rq.pop_front() : 99'h1, {67'h0, reg_rdata});
		end
		if (nv_save === 1'b1) begin
			chk("nv_data", sq.size() != 0 ? sq.pop_front() : 99'h1, nv_data);
		end
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		finish_test;
	end

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		logic [31:0] x;
		void'($urandom(19231));
		{rst_b, reg_wr, reg_rd, e1, e2, f1, f2, traj_phase, client_count, reg_addr} = '0;
		{pwm_duty, traj_speed_cmd, traj_target, reg_wdata} = '0;
		drive_enable = 1'b1;
		p1 = 8'h01;
		p2 = 8'h01;
		repeat (16) cyc;
		rst_b = 1'b1;
		cyc;
		chk("drive_mode", dem_pkg::LOOP_BRAKE, drive_mode);
		rd(dem_pkg::ADDR_RATIO, dem_pkg::RATIO_RESET);
		rd(8'h60, 32'h0);
		rd(dem_pkg::ADDR_TUNE, 32'h0);
		go(8'h02, 1'b1, 8'h02, 1'b1, 40);
		rd(dem_pkg::ADDR_POSITION, 32'h14);
		go(8'h02, 1'b0, 8'h00, 1'b0, 12);
		wr(dem_pkg::ADDR_POSITION, 32'h5a5a);
		rd(dem_pkg::ADDR_POSITION, 32'he);
		wr(dem_pkg::ADDR_FLAGS, 32'h400);
		go(8'h02, 1'b1, 8'h02, 1'b1, 20);
		rd(dem_pkg::ADDR_POSITION, 32'ha);
		wr(dem_pkg::ADDR_FLAGS, 32'hc00);
		go(8'h00, 1'b0, 8'h02, 1'b1, 8);
		rd(dem_pkg::ADDR_POSITION, 32'h6);
		wr(dem_pkg::ADDR_FLAGS, 32'h400);
		rd(dem_pkg::ADDR_FLAGS, 32'h400);
		// Ten motor steps per 100-cycle gate, while the output encoder runs faster.
		fork
			go(8'h0a, 1'b1, 8'h05, 1'b1, 300);
			begin
				repeat (250) cyc;
				rd(dem_pkg::ADDR_SPEED, 32'd1000);
			end
		join
		wr(dem_pkg::ADDR_RATIO, $urandom | 32'h1);
		fork
			go(8'h04, 1'b1, 8'h08, 1'b1, 320);
			begin
				repeat (8) cyc;
				wr(dem_pkg::ADDR_TUNE, 32'h1);
			end
		join
		repeat (60) cyc;
		rd(dem_pkg::ADDR_RATIO, 32'h0002_0000);
		rd(dem_pkg::ADDR_POSITION, 32'd106);
		wr(dem_pkg::ADDR_RATIO, 32'h0003_0000);
		traj_target = 32'd266;
		traj_phase = dem_pkg::PHASE_DECEL;
		repeat (3) cyc;
		chk("motor_speed_cmd", 32'd30, motor_speed_cmd);
		chk("traj_feedback", 32'd106, traj_feedback);
		x = $urandom;
		traj_speed_cmd = x;
		traj_phase = dem_pkg::PHASE_ACCEL;
		repeat (3) cyc;
		chk("motor_speed_cmd", x, motor_speed_cmd);
		chk("traj_feedback", 32'd134, traj_feedback);
		traj_phase = dem_pkg::PHASE_TOP;
		repeat (2) cyc;
		chk("motor_speed_cmd", x, motor_speed_cmd);
		chk("traj_feedback", 32'd134, traj_feedback);
		for (int i = 0; i < 5; i++) begin
			wr(dem_pkg::ADDR_LOOP_SEL, i);
			chk("drive_mode", i, drive_mode);
		end
		drive_enable = 1'b0;
		repeat (2) cyc;
		chk("drive_mode", 3'h0, drive_mode);
		wr(dem_pkg::ADDR_LOOP_SEL, 32'h3);
		drive_enable = 1'b1;
		repeat (3) cyc;
		chk("drive_mode", 3'h0, drive_mode);
		wr(dem_pkg::ADDR_LOOP_SEL, 32'h3);
		chk("drive_mode", 3'h3, drive_mode);
		for (int i = 0; i < 8; i++) begin
			pwm_duty = i < 5 ? dl[i] : 17'($urandom_range(65536));
			repeat (2) cyc;
			chk("led_colour", pwm_duty >= dem_pkg::DUTY_FULL ? dem_pkg::LED_RED :
				pwm_duty > dem_pkg::DUTY_75 ? dem_pkg::LED_YELLOW : dem_pkg::LED_GREEN, led_colour);
		end
		x = $urandom;
		client_count = 8'h02;
		wr(dem_pkg::ADDR_NET_ADDR, x);
		repeat (2) cyc;
		chk("net_addr_active", 32'h0, net_addr_active);
		rd(dem_pkg::ADDR_NET_ADDR, x);
		client_count = 8'h00;
		repeat (2) cyc;
		chk("net_addr_active", x, net_addr_active);
		sq.push_back({3'h3, x, 32'h0003_0000, 32'h400});
		wr(dem_pkg::ADDR_SAVE, 32'h1);
		rd(dem_pkg::ADDR_SAVE, 32'h0);
		for (int i = 0; i < 8 && sq.size() != 0; i++) cyc;
		chk("pending results", 99'h0, 99'(sq.size() + rq.size()));
		finish_test;
	end
endmodule
